// file: hw/bts_pkg.sv
// Constants shared by the bit-test-and-skip decoder.
package bts_pkg;
  localparam int          INSTR_W      = 12;
  localparam int          OPC_W        = 4;
  localparam logic [3:0]  OPC_SKIP_CLR = 4'h6;
  localparam logic [3:0]  OPC_SKIP_SET = 4'h7;
  localparam int          OPC_LSB      = 8;
  localparam int          BIT_LSB      = 5;
  localparam int          BIT_W        = 3;
  localparam int          ADDR_LSB     = 0;
  localparam int          ADDR_W       = 5;
  localparam logic [11:0] NOP_WORD     = 12'h000;
  localparam logic        SKIP_RST     = 1'b0;
  localparam int          SKIP_CYCLES  = 2;
endpackage

// file: hw/bts_field.sv
// Field extractor and opcode recogniser for one instruction word.
`timescale 1ns/1ps
module bts_field #(
  parameter int INSTR_W = bts_pkg::INSTR_W
) (
  input  wire logic [INSTR_W-1:0]        instr,
  output logic                           is_clr,
  output logic                           is_set,
  output logic [bts_pkg::BIT_W-1:0]      bit_idx,
  output logic [bts_pkg::ADDR_W-1:0]     reg_addr
);
  logic [bts_pkg::OPC_W-1:0] opc;
  assign opc      = instr[bts_pkg::OPC_LSB +: bts_pkg::OPC_W];
  assign is_clr   = (opc == bts_pkg::OPC_SKIP_CLR);
  assign is_set   = (opc == bts_pkg::OPC_SKIP_SET);
  assign bit_idx  = instr[bts_pkg::BIT_LSB +: bts_pkg::BIT_W];
  assign reg_addr = instr[bts_pkg::ADDR_LSB +: bts_pkg::ADDR_W];
endmodule // bts_field

// file: hw/bts_decode.sv
// Bit-test-and-skip decode and execute stage.
`timescale 1ns/1ps
// Contract
// - Opcode 0110 bbb fffff is bit_test_skip_clear, 3-bit index, 5-bit address.
// - Opcode 0111 bbb fffff is bit_test_skip_set, same field layout.
// - Clear variant skips next instruction only when tested bit is zero.
// - Set variant skips next instruction only when tested bit is one.
// - On skip the prefetched word is discarded and a no-op executes instead.
// - One word; one cycle without skip, two cycles with skip.
module bts_decode #(
  parameter int INSTR_W = bts_pkg::INSTR_W
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  input  wire logic                       instr_valid,
  input  wire logic [INSTR_W-1:0]         instr,
  input  wire logic [7:0]                 reg_rdata,
  output logic [bts_pkg::ADDR_W-1:0]      reg_raddr,
  output logic                            is_test,
  output logic                            skip_taken,
  output logic                            squash,
  output logic [INSTR_W-1:0]              exec_word,
  output logic                            exec_valid,
  output logic                            reg_we,
  output logic                            status_we
);
  typedef enum logic [0:0] {
    BTS_RUN    = 1'b0,
    BTS_SQUASH = 1'b1
  } bts_state_e;

  logic                        dec_clr;
  logic                        dec_set;
  logic [bts_pkg::BIT_W-1:0]   dec_bit;
  logic [bts_pkg::ADDR_W-1:0]  dec_addr;
  bts_state_e                  state;
  bts_state_e                  next_state;
  logic                        tested;
  logic                        want_skip;
  logic [bts_pkg::ADDR_W-1:0]  next_reg_raddr;
  logic                        next_is_test;
  logic                        next_skip_taken;
  logic                        next_squash;
  logic [INSTR_W-1:0]          next_exec_word;
  logic                        next_exec_valid;

  bts_field #(.INSTR_W(INSTR_W)) u_field (
    .instr    (instr),
    .is_clr   (dec_clr),
    .is_set   (dec_set),
    .bit_idx  (dec_bit),
    .reg_addr (dec_addr)
  );

  // The tested bit comes from reg_rdata in the decode cycle; reg_raddr carries the decoded address one cycle later.
  assign tested = reg_rdata[dec_bit];

  always_comb begin
    want_skip = 1'b0;
    if (dec_clr && !tested) begin
      want_skip = 1'b1;
    end else if (dec_set && tested) begin
      want_skip = 1'b1;
    end
  end

  always_comb begin
    next_state      = state;
    next_reg_raddr  = dec_addr;
    next_is_test    = 1'b0;
    next_skip_taken = 1'b0;
    next_squash     = 1'b0;
    next_exec_word  = instr;
    next_exec_valid = 1'b0;
    case (state)
      BTS_RUN: begin
        if (instr_valid) begin
          next_exec_valid = 1'b1;
          next_is_test    = dec_clr || dec_set;
          if (want_skip) begin
            next_skip_taken = 1'b1;
            next_state      = BTS_SQUASH;
          end
        end
      end
      BTS_SQUASH: begin
        // The prefetched word is replaced, so its effects never occur.
        if (instr_valid) begin
          next_exec_word  = bts_pkg::NOP_WORD;
          next_exec_valid = 1'b1;
          next_squash     = 1'b1;
          next_state      = BTS_RUN;
        end
      end
      default: begin
        next_state = BTS_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= BTS_RUN;
      reg_raddr  <= '0;
      is_test    <= 1'b0;
      skip_taken <= bts_pkg::SKIP_RST;
      squash     <= 1'b0;
      exec_word  <= bts_pkg::NOP_WORD;
      exec_valid <= 1'b0;
      reg_we     <= 1'b0;
      status_we  <= 1'b0;
    end else if (clk_en) begin
      state      <= next_state;
      reg_raddr  <= next_reg_raddr;
      is_test    <= next_is_test;
      skip_taken <= next_skip_taken;
      squash     <= next_squash;
      exec_word  <= next_exec_word;
      exec_valid <= next_exec_valid;
      reg_we     <= 1'b0;
      status_we  <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_SKIP_CLR: assert property (clk_en && instr_valid && state == BTS_RUN
      && dec_clr && !tested |=> skip_taken && is_test)
    else $error("clear skip not taken");
  AST_SKIP_SET: assert property (clk_en && instr_valid && state == BTS_RUN
      && dec_set && tested |=> skip_taken)
    else $error("set skip not taken");
  AST_NO_SKIP: assert property (clk_en && instr_valid && state == BTS_RUN
      && !want_skip |=> !skip_taken)
    else $error("skip taken without cause");
  AST_DECODE: assert property (clk_en && instr_valid && state == BTS_RUN
      && instr[11:8] == bts_pkg::OPC_SKIP_CLR |=> is_test)
    else $error("clear opcode missed");

  AST_DECODE_SET: assert property (clk_en && instr_valid && state == BTS_RUN
      && instr[11:8] == bts_pkg::OPC_SKIP_SET |=> is_test)
    else $error("set opcode missed");

  // The squash lands on the first accepted word after the test, which may
  // be presented in the very cycle that shows skip_taken.
  AST_SQUASH: assert property (clk_en && instr_valid && state == BTS_SQUASH
      |=> squash && exec_word == bts_pkg::NOP_WORD && exec_valid)
    else $error("prefetched word not squashed");

  // A held clock enable freezes squash, so only an accepted edge ends it.
  AST_TWO_CYC: assert property (squash && clk_en |=> !squash)
    else $error("skip lasted more than two cycles");

  AST_NO_WRITE: assert property (exec_valid |-> !reg_we && !status_we)
    else $error("test instruction wrote state");

  // A squashed slot never starts a skip of its own.
  AST_SQ_NOSKIP: assert property (clk_en && instr_valid
      && state == BTS_SQUASH |=> !skip_taken && !is_test)
    else $error("squashed word was decoded");

  // Without a skip the instruction takes a single cycle.
  AST_ONE_CYC: assert property (clk_en && instr_valid && state == BTS_RUN
      && !want_skip |=> state == BTS_RUN)
    else $error("non-skipping test took two cycles");

  // An unsquashed word passes to execution unchanged.
  AST_WORD_PASS: assert property (clk_en && instr_valid && state == BTS_RUN
      |=> exec_word == $past(instr) && exec_valid && !squash)
    else $error("executed word differs from fetched word");

  // The register address follows the decoded field.
  AST_ADDR: assert property (clk_en
      |=> reg_raddr == $past(dec_addr))
    else $error("register address differs from field");

  // Low clock enable holds every output.
  AST_FREEZE: assert property (!clk_en |=> $stable(exec_word)
      && $stable(exec_valid) && $stable(squash)
      && $stable(skip_taken) && $stable(is_test))
    else $error("state moved while clock enable low");

  // The status write strobe never rises.
  AST_NO_STATUS: assert property (!status_we && !reg_we)
    else $error("write strobe raised");

  COV_CLR: cover property (skip_taken ##[1:4] squash);
  COV_SET: cover property (clk_en && dec_set && tested && instr_valid);
  COV_NOSKIP: cover property (is_test && !skip_taken);
  COV_BACK2BACK: cover property (skip_taken && clk_en && instr_valid
      ##1 squash);
  COV_HELD: cover property (state == BTS_SQUASH && !clk_en ##1 squash);
endmodule // bts_decode

// file: verif/bit_test_skip_decode_bench.sv
// Self-checking bench for the bit-test-and-skip decode stage.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
  n_fail++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module bit_test_skip_decode_bench;
  logic        sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b0, instr_valid = 1'b0;
  logic [11:0] instr = '0, e_word, exec_word;
  logic [7:0]  reg_rdata = '0;
  logic [4:0]  reg_raddr, e_addr;
  logic        is_test, skip_taken, squash, exec_valid, reg_we, status_we;
  logic        e_valid, e_test, e_skip, e_squash, pend;
  int          n_fail = 0, samples_checked = 0;
  bts_decode u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr(instr), .reg_rdata(reg_rdata),
    .reg_raddr(reg_raddr), .is_test(is_test), .skip_taken(skip_taken),
    .squash(squash), .exec_word(exec_word), .exec_valid(exec_valid),
    .reg_we(reg_we), .status_we(status_we));
  always #25 sys_clk = ~sys_clk;
  function automatic logic is_tst(logic [11:0] w);
    return w[11:8] == bts_pkg::OPC_SKIP_CLR || w[11:8] == bts_pkg::OPC_SKIP_SET;
  endfunction
  // The tested bit decides the skip; clear variant inverts the sense.
  function automatic logic skip_of(logic [11:0] w, logic [7:0] d);
    return (w[11:8] == bts_pkg::OPC_SKIP_CLR && !d[w[7:5]]) ||
           (w[11:8] == bts_pkg::OPC_SKIP_SET && d[w[7:5]]);
  endfunction
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {e_valid, e_test, e_skip, e_squash, pend} <= '0;
    end else if (clk_en) begin
      e_valid  <= instr_valid;
      e_squash <= instr_valid && pend;
      e_test   <= instr_valid && !pend && is_tst(instr);
      e_skip   <= instr_valid && !pend && skip_of(instr, reg_rdata);
      if (instr_valid) begin
        pend   <= !pend && skip_of(instr, reg_rdata);
        e_word <= pend ? bts_pkg::NOP_WORD : instr;
        e_addr <= instr[4:0];
      end
    end
  end
  always @(negedge sys_clk) begin
    if (rst_b) begin
      `CHK("exec_valid", e_valid, exec_valid)
      `CHK("skip_taken", e_skip, skip_taken)
      `CHK("squash", e_squash, squash)
      `CHK("reg_we", 1'b0, reg_we)
      `CHK("status_we", 1'b0, status_we)
      if (!e_squash) `CHK("is_test", e_test, is_test)
      if (e_valid) `CHK("exec_word", e_word, exec_word)
      if (e_valid && !e_squash) `CHK("reg_raddr", e_addr, reg_raddr)
    end
  end
  task automatic drive(logic en, logic v, logic [11:0] w, logic [7:0] d);
    @(posedge sys_clk);
    clk_en      <= en;
    instr_valid <= v;
    instr       <= w;
    reg_rdata   <= d;
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  initial begin
    logic [11:0] w;
    void'($urandom(32'h29b9));
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 32; k++) begin
      w = {4'h6 + 4'(k[4]), 3'(k[2:0]), 5'($urandom)};
      drive(1'b1, 1'b1, w, k[3] ? 8'h01 << k[2:0] : ~(8'h01 << k[2:0]));
      if (k[3]) drive(1'b0, 1'b1, 12'h7ff, 8'hff);
      if (k[1]) drive(1'b1, 1'b0, 12'h6e0, 8'h00);
      drive(1'b1, 1'b1, 12'(k * 67), 8'($urandom));
    end
    repeat (1500) begin
      w = {4'($urandom_range(4, 8)), 8'($urandom)};
      drive($urandom_range(0, 7) != 0, $urandom_range(0, 5) != 0, w,
            8'($urandom));
    end
    drive(1'b1, 1'b0, '0, '0);
    @(posedge sys_clk);
    conclude();
  end
endmodule // bit_test_skip_decode_bench
